// >>> vectored_exception_prioritizer.sv
// Exception and interrupt prioritizer with vectored entry, stacking and tail-chaining.
// Assumes an APB master, a core on pclk handshaking entry and return, raw interrupt pins.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "vep_params.svh"
module vectored_exception_prioritizer #(
   parameter int NEST = 8
) (
   // Clock, reset, freeze
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Event sources
   input wire logic [47:0] irq_lines,
   input wire logic fault_mem_req,
   input wire logic fault_bus_req,
   input wire logic fault_bus_precise,
   input wire logic fault_usage_req,
   input wire logic svc_req,
   input wire logic dbgmon_req,
   input wire logic system_tick_exception_req,
   // Core handshake
   input wire logic first_instr,
   input wire logic exc_return,
   output logic sp_load,
   output logic vtab_rd,
   output vep_pkg::vec_t vtab_index,
   output logic stack_push,
   output logic stack_pop,
   output logic tail_chain,
   output logic handler_mode,
   output vep_pkg::vec_t active_vec
);
   import vep_pkg::*;
   localparam int DW = $clog2(NEST);
   localparam int STK = `STACK_CYCLES;
   localparam logic [47:0] IMPL = `IRQ_IMPL_MASK;

   arb_if ab ();
   exc_arbiter u_arb (.ab(ab));

   state_t state_r;
   logic [3:0] cnt_r;
   logic [DW:0] depth_r;
   vec_t act_vec_r [NEST];
   grp_t act_grp_r [NEST];
   vec_t fetch_vec_r, active_vec_r;
   logic [63:0] pend_r, pend_set, pend_clr;
   logic [47:0] en_r, irq_s1, irq_s2, irq_s3, irq_lvl_r;
   prio_t irq_prio_r [`NUM_IRQ];
   prio_t sys_prio_r [`NUM_SYS];
   logic [1:0] split_r;
   logic mem_en_r, bus_en_r, usage_en_r, dbgmon_en_r;
   logic [31:0] rd_val, prdata_r;
   logic ready_r, err, wr_en, wr_ctrl, prio_hit;
   logic [2:0] prio_word;
   grp_t cur_grp, grp_below;
   logic preempt, tail_ok, take;

   function automatic rank_t settable(input prio_t p, input logic [1:0] split);
      prio_t sub_mask;
      sub_mask = ~(3'h7 << split);
      return {grp_t'(`GRP_SETTABLE) + grp_t'(p >> split), p & sub_mask};
   endfunction : settable

   function automatic vec_t sys_vec(input int k);
      vec_t v;
      v = `VEC_MEM;
      case (k)
         1: v = `VEC_BUS;
         2: v = `VEC_USAGE;
         3: v = `VEC_SVC;
         4: v = `VEC_DBGMON;
         5: v = `VEC_PENDABLE_SERVICE_REQUEST;
         6: v = `VEC_SYSTEM_TICK_EXCEPTION;
         default: v = `VEC_MEM;
      endcase
      return v;
   endfunction : sys_vec

   function automatic vec_t fault_target(input logic en, input rank_t r, input grp_t cur, input vec_t v);
      return (en && r[6:3] < cur) ? v : `VEC_HARD;
   endfunction : fault_target

   always_comb begin
      for (int i = 0; i < `NUM_VEC; i++) begin
         ab.rank[i] = '1;
      end
      ab.rank[`VEC_NMI] = {`GRP_NMI, 3'h0};
      ab.rank[`VEC_HARD] = {`GRP_HARD, 3'h0};
      for (int k = 0; k < `NUM_SYS; k++) begin
         ab.rank[sys_vec(k)] = settable(sys_prio_r[k], split_r);
      end
      for (int j = 0; j < `NUM_IRQ; j++) begin
         ab.rank[`VEC_IRQ0 + j] = settable(irq_prio_r[j], split_r);
      end
   end

   assign ab.pend = pend_r & {en_r & IMPL, 16'hffff};

   // APB decode
   assign prio_hit = paddr >= `OFS_IRQ_PRIO && paddr < `OFS_IRQ_PRIO_END && paddr[1:0] == 2'h0;
   assign prio_word = 3'(paddr[11:2] - 10'(`OFS_IRQ_PRIO >> 2));
   assign pready = ready_r & ce;
   assign wr_en = psel & penable & pwrite & pready & ~err;
   assign wr_ctrl = wr_en && paddr == `OFS_CTRLSTATE;
   assign pslverr = psel & penable & pready & err;
   assign prdata = prdata_r;

   always_comb begin
      rd_val = 32'h0;
      err = 1'b0;
      if (prio_hit) begin
         for (int k = 0; k < 8; k++) begin
            rd_val[`PRIO_FIELD_W*k +: 3] = irq_prio_r[8*prio_word + k];
         end
      end else begin
         case (paddr)
            `OFS_CTRLSTATE: begin
               rd_val[`BIT_NMI_SET] = pend_r[`VEC_NMI];
               rd_val[`BIT_PENDABLE_SERVICE_REQUEST_SET] = pend_r[`VEC_PENDABLE_SERVICE_REQUEST];
               rd_val[`POS_PEND_VEC +: 6] = ab.best_vec;
               rd_val[5:0] = active_vec_r;
            end
            `OFS_HANDLER_EN: begin
               rd_val[`BIT_MEM_EN] = mem_en_r;
               rd_val[`BIT_BUS_EN] = bus_en_r;
               rd_val[`BIT_USAGE_EN] = usage_en_r;
               rd_val[`BIT_DBGMON_EN] = dbgmon_en_r;
            end
            `OFS_GROUPING: rd_val[1:0] = split_r;
            `OFS_SYS_PRIO: begin
               for (int k = 0; k < `NUM_SYS; k++) begin
                  rd_val[`PRIO_FIELD_W*k +: 3] = sys_prio_r[k];
               end
            end
            `OFS_SET_EN0, `OFS_CLR_EN0: rd_val = en_r[31:0];
            `OFS_SET_EN1, `OFS_CLR_EN1: rd_val = {16'h0, en_r[47:32]};
            `OFS_PEND0: rd_val = pend_r[47:16];
            `OFS_PEND1: rd_val = {16'h0, pend_r[63:48]};
            default: err = 1'b1;
         endcase
      end
   end

   // Ready follows any selected cycle, so a setup frozen by ce still completes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
         ready_r <= 1'b0;
      end else if (ce) begin
         if (psel && !ready_r) begin
            prdata_r <= rd_val;
            ready_r <= 1'b1;
         end else if (psel && penable) begin
            ready_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int j = 0; j < `NUM_IRQ; j++) begin
            irq_prio_r[j] <= `RST_PRIO;
         end
         for (int k = 0; k < `NUM_SYS; k++) begin
            sys_prio_r[k] <= `RST_PRIO;
         end
         split_r <= `RST_SPLIT;
      end else if (ce && wr_en) begin
         if (prio_hit) begin
            for (int k = 0; k < 8; k++) begin
               if (IMPL[8*prio_word + k]) begin
                  irq_prio_r[8*prio_word + k] <= pwdata[`PRIO_FIELD_W*k +: 3];
               end
            end
         end else if (paddr == `OFS_SYS_PRIO) begin
            for (int k = 0; k < `NUM_SYS; k++) begin
               sys_prio_r[k] <= pwdata[`PRIO_FIELD_W*k +: 3];
            end
         end else if (paddr == `OFS_GROUPING) begin
            split_r <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r <= '0;
         mem_en_r <= `RST_EN;
         bus_en_r <= `RST_EN;
         usage_en_r <= `RST_EN;
         dbgmon_en_r <= `RST_EN;
      end else if (ce && wr_en) begin
         case (paddr)
            `OFS_SET_EN0: en_r <= en_r | ({16'h0, pwdata} & IMPL);
            `OFS_SET_EN1: en_r <= en_r | ({pwdata[15:0], 32'h0} & IMPL);
            `OFS_CLR_EN0: en_r <= en_r & ~{16'h0, pwdata};
            `OFS_CLR_EN1: en_r <= en_r & ~{pwdata[15:0], 32'h0};
            `OFS_HANDLER_EN: begin
               mem_en_r <= pwdata[`BIT_MEM_EN];
               bus_en_r <= pwdata[`BIT_BUS_EN];
               usage_en_r <= pwdata[`BIT_USAGE_EN];
               dbgmon_en_r <= pwdata[`BIT_DBGMON_EN];
            end
            default: en_r <= en_r;
         endcase
      end
   end

   // Pins: three stages, a change counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_s1 <= '0;
         irq_s2 <= '0;
         irq_s3 <= '0;
         irq_lvl_r <= '0;
      end else if (ce) begin
         irq_s1 <= irq_lines;
         irq_s2 <= irq_s1;
         irq_s3 <= irq_s2;
         irq_lvl_r <= (irq_s2 & irq_s3) | (irq_lvl_r & (irq_s2 | irq_s3));
      end
   end

   always_comb begin
      pend_set = '0;
      pend_clr = '0;
      if (take) begin
         pend_clr[ab.best_vec] = 1'b1;
      end
      if (wr_ctrl && pwdata[`BIT_PENDABLE_SERVICE_REQUEST_CLR]) begin
         pend_clr[`VEC_PENDABLE_SERVICE_REQUEST] = 1'b1;
      end
      if (wr_ctrl && pwdata[`BIT_NMI_SET]) begin
         pend_set[`VEC_NMI] = 1'b1;
      end
      if (wr_ctrl && pwdata[`BIT_PENDABLE_SERVICE_REQUEST_SET]) begin
         pend_set[`VEC_PENDABLE_SERVICE_REQUEST] = 1'b1;
      end
      if (fault_mem_req) begin
         pend_set[fault_target(mem_en_r, ab.rank[`VEC_MEM], cur_grp, `VEC_MEM)] = 1'b1;
      end
      if (fault_usage_req) begin
         pend_set[fault_target(usage_en_r, ab.rank[`VEC_USAGE], cur_grp, `VEC_USAGE)] = 1'b1;
      end
      if (fault_bus_req && fault_bus_precise) begin
         pend_set[fault_target(bus_en_r, ab.rank[`VEC_BUS], cur_grp, `VEC_BUS)] = 1'b1;
      end else if (fault_bus_req) begin
         pend_set[bus_en_r ? `VEC_BUS : `VEC_HARD] = 1'b1;
      end
      if (svc_req) begin
         pend_set[`VEC_SVC] = 1'b1;
      end
      if (dbgmon_req && dbgmon_en_r && ab.rank[`VEC_DBGMON][6:3] < cur_grp) begin
         pend_set[`VEC_DBGMON] = 1'b1;
      end
      if (system_tick_exception_req) begin
         pend_set[`VEC_SYSTEM_TICK_EXCEPTION] = 1'b1;
      end
      pend_set[63:16] = irq_lvl_r & en_r & IMPL;
   end

   // Set wins over clear, so a line still high re-pends after being taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r <= '0;
      end else if (ce) begin
         pend_r <= (pend_r & ~pend_clr) | pend_set;
      end
   end

   always_comb begin
      if (state_r == ST_SPLOAD || state_r == ST_RSTVEC || state_r == ST_RSTRUN) begin
         cur_grp = `GRP_RESET;
      end else if (depth_r == '0) begin
         cur_grp = `GRP_BASE;
      end else begin
         cur_grp = act_grp_r[DW'(depth_r - 1'b1)];
      end
      grp_below = (depth_r > 1) ? act_grp_r[DW'(depth_r - 2'h2)] : `GRP_BASE;
   end

   assign preempt = ab.best_valid && ab.best_grp < cur_grp && depth_r < (DW+1)'(NEST);
   // chain when it would preempt the level below
   assign tail_ok = ab.best_valid && ab.best_grp < grp_below;
   assign take = ((state_r == ST_THREAD || (state_r == ST_HANDLER && !exc_return)) && preempt) ||
                 (state_r == ST_HANDLER && exc_return && tail_ok);

   // Deep nesting stalls new entries instead of overflowing the stack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_SPLOAD;
         cnt_r <= 4'h0;
         fetch_vec_r <= `VEC_SP;
         active_vec_r <= 6'h00;
      end else if (ce) begin
         unique case (state_r)
            ST_SPLOAD: begin
               state_r <= ST_RSTVEC;
               fetch_vec_r <= `VEC_RESET;
               active_vec_r <= `VEC_RESET;
            end
            ST_RSTVEC: state_r <= ST_RSTRUN;
            ST_RSTRUN: begin
               if (first_instr) begin
                  state_r <= ST_THREAD;
                  active_vec_r <= 6'h00;
               end
            end
            ST_THREAD, ST_HANDLER: begin
               if (take) begin
                  fetch_vec_r <= ab.best_vec;
                  active_vec_r <= ab.best_vec;
                  cnt_r <= 4'h0;
                  state_r <= (state_r == ST_HANDLER && exc_return) ? ST_TAIL : ST_ENTRY;
               end else if (state_r == ST_HANDLER && exc_return) begin
                  cnt_r <= 4'h0;
                  state_r <= ST_UNSTACK;
                  active_vec_r <= (depth_r > 1) ? act_vec_r[DW'(depth_r - 2'h2)] : 6'h00;
               end
            end
            ST_ENTRY: begin
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == 4'(STK - 1)) begin
                  state_r <= ST_HANDLER;
               end
            end
            ST_TAIL: state_r <= ST_HANDLER;
            ST_UNSTACK: begin
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == 4'(STK - 1)) begin
                  state_r <= (depth_r == '0) ? ST_THREAD : ST_HANDLER;
               end
            end
         endcase
      end
   end

   // Active exceptions, newest on top
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         depth_r <= '0;
         for (int i = 0; i < NEST; i++) begin
            act_vec_r[i] <= 6'h00;
            act_grp_r[i] <= `GRP_BASE;
         end
      end else if (ce) begin
         if (take && state_r == ST_HANDLER && exc_return) begin
            act_vec_r[DW'(depth_r - 1'b1)] <= ab.best_vec;
            act_grp_r[DW'(depth_r - 1'b1)] <= ab.best_grp;
         end else if (take) begin
            act_vec_r[DW'(depth_r)] <= ab.best_vec;
            act_grp_r[DW'(depth_r)] <= ab.best_grp;
            depth_r <= depth_r + 1'b1;
         end else if (state_r == ST_HANDLER && exc_return) begin
            depth_r <= depth_r - 1'b1;
         end
      end
   end

   assign sp_load = state_r == ST_SPLOAD;
   assign vtab_rd = sp_load || state_r == ST_RSTVEC || state_r == ST_TAIL || (state_r == ST_ENTRY && cnt_r == 4'h0);
   assign vtab_index = fetch_vec_r;
   assign stack_push = state_r == ST_ENTRY;
   assign stack_pop = state_r == ST_UNSTACK;
   assign tail_chain = state_r == ST_TAIL;
   assign handler_mode = state_r == ST_HANDLER || state_r == ST_TAIL;
   assign active_vec = active_vec_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !ce);

   logic nest_ok, en_best;
   assign nest_ok = depth_r < 2 || act_grp_r[DW'(depth_r - 1'b1)] < act_grp_r[DW'(depth_r - 2'h2)];
   assign en_best = ab.best_vec < 6'h10 || en_r[6'(ab.best_vec - 6'h10)];

   property p_sp_entry0;
      sp_load |-> vtab_rd && vtab_index == 6'h00;
   endproperty
   a_sp_entry0: assert property (p_sp_entry0) else $error("sp not from entry 0");
   property p_reset_vec;
      sp_load |=> vtab_rd && vtab_index == 6'h01 && active_vec == 6'h01;
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("reset vector not fetched");
   property p_fetch_parallel;
      $rose(stack_push) |-> vtab_rd && vtab_index == active_vec;
   endproperty
   a_fetch_parallel: assert property (p_fetch_parallel) else $error("fetch not with push");
   property p_stacking;
      $rose(stack_push) |-> stack_push [*8] ##1 (!stack_push && handler_mode);
   endproperty
   a_stacking: assert property (p_stacking) else $error("stacking length wrong");
   property p_tail;
      tail_chain |-> vtab_rd && !stack_push && !stack_pop ##1 handler_mode && !stack_push;
   endproperty
   a_tail: assert property (p_tail) else $error("tail chain restacked");
   property p_nmi_hold;
      state_r == ST_HANDLER && active_vec_r == `VEC_NMI && !exc_return |=> active_vec_r == `VEC_NMI;
   endproperty
   a_nmi_hold: assert property (p_nmi_hold) else $error("nmi preempted");
   property p_escalate;
      fault_mem_req && !mem_en_r |=> pend_r[3];
   endproperty
   a_escalate: assert property (p_escalate) else $error("fault not escalated");
   property p_dbgmon;
      $rose(pend_r[12]) |-> $past(dbgmon_en_r && dbgmon_req);
   endproperty
   a_dbgmon: assert property (p_dbgmon) else $error("debug monitor pended while off");
   property p_pendable_service_request_sw;
      $rose(pend_r[14]) |-> $past(wr_ctrl && pwdata[`BIT_PENDABLE_SERVICE_REQUEST_SET]);
   endproperty
   a_pendable_service_request_sw: assert property (p_pendable_service_request_sw) else $error("pendable_service_request not from software");
   property p_nesting;
      handler_mode |-> nest_ok;
   endproperty
   a_nesting: assert property (p_nesting) else $error("nested without urgency");
   property p_enabled;
      ab.best_valid |-> en_best;
   endproperty
   a_enabled: assert property (p_enabled) else $error("disabled line arbitrated");

   c_tail: cover property (tail_chain);
   c_nested: cover property (handler_mode && depth_r == 2);
   c_nmi: cover property (handler_mode && active_vec_r == `VEC_NMI);
   c_hard: cover property (handler_mode && active_vec_r == `VEC_HARD);
endmodule : vectored_exception_prioritizer

// >>> vep_params.svh
// Offsets, field positions, reset values and timing counts of the exception prioritizer.
// Included by the package, the prioritizer and the arbiter; definitions only.
`ifndef VEP_PARAMS_SVH
`define VEP_PARAMS_SVH

// Register byte offsets
`define OFS_CTRLSTATE 12'h000
`define OFS_HANDLER_EN 12'h004
`define OFS_GROUPING 12'h008
`define OFS_SYS_PRIO 12'h00c
`define OFS_SET_EN0 12'h010
`define OFS_SET_EN1 12'h014
`define OFS_CLR_EN0 12'h018
`define OFS_CLR_EN1 12'h01c
`define OFS_PEND0 12'h020
`define OFS_PEND1 12'h024
`define OFS_IRQ_PRIO 12'h040
`define OFS_IRQ_PRIO_END 12'h058

// Field positions
`define BIT_NMI_SET 31
`define BIT_PENDABLE_SERVICE_REQUEST_SET 28
`define BIT_PENDABLE_SERVICE_REQUEST_CLR 27
`define POS_PEND_VEC 12
`define BIT_MEM_EN 16
`define BIT_BUS_EN 17
`define BIT_USAGE_EN 18
`define BIT_DBGMON_EN 19
`define PRIO_FIELD_W 4

// Reset values
`define RST_PRIO 3'h0
`define RST_SPLIT 2'h0
`define RST_EN 1'b0

// Exception numbers
`define VEC_SP 6'h00
`define VEC_RESET 6'h01
`define VEC_NMI 6'h02
`define VEC_HARD 6'h03
`define VEC_MEM 6'h04
`define VEC_BUS 6'h05
`define VEC_USAGE 6'h06
`define VEC_SVC 6'h0b
`define VEC_DBGMON 6'h0c
`define VEC_PENDABLE_SERVICE_REQUEST 6'h0e
`define VEC_SYSTEM_TICK_EXCEPTION 6'h0f
`define VEC_IRQ0 16
`define NUM_VEC 64
`define NUM_IRQ 48
`define NUM_SYS 7

// Preemption groups, smaller is more urgent
`define GRP_RESET 4'h0
`define GRP_NMI 4'h1
`define GRP_HARD 4'h2
`define GRP_SETTABLE 4'h3
`define GRP_BASE 4'hf

// Implemented peripheral lines
`define IRQ_IMPL_MASK 48'h0c00_f3ff_c1ff

// Cycles of automatic stacking and of unstacking
`define STACK_CYCLES 8

`endif

// >>> vep_pkg.sv
// Types shared by the exception prioritizer and its arbiter.
// Assumes vep_params.svh is on the include path.
`include "vep_params.svh"
package vep_pkg;
   typedef logic [2:0] prio_t;
   typedef logic [3:0] grp_t;
   typedef logic [6:0] rank_t;
   typedef logic [5:0] vec_t;
   typedef enum logic [2:0] {
      ST_SPLOAD = 3'h0,
      ST_RSTVEC = 3'h1,
      ST_RSTRUN = 3'h2,
      ST_THREAD = 3'h3,
      ST_ENTRY = 3'h4,
      ST_HANDLER = 3'h5,
      ST_TAIL = 3'h6,
      ST_UNSTACK = 3'h7
   } state_t;
endpackage : vep_pkg

// >>> arb_if.sv
// Pending set and ranks going to the arbiter, winner coming back.
// Assumes vep_pkg is compiled first.
`timescale 1ns/1ps
interface arb_if;
   import vep_pkg::*;
   logic [63:0] pend;
   rank_t rank [64];
   vec_t best_vec;
   grp_t best_grp;
   logic best_valid;
   modport ctl (output pend, output rank, input best_vec, input best_grp, input best_valid);
   modport arb (input pend, input rank, output best_vec, output best_grp, output best_valid);
endinterface : arb_if

// >>> exc_arbiter.sv
// Combinational winner search over all pending exception numbers.
// Assumes ranks of {group, subpriority}; strict compare keeps the lower number on ties.
`timescale 1ns/1ps
`include "vep_params.svh"
module exc_arbiter (
   // Pending set and winner
   arb_if.arb ab
);
   import vep_pkg::*;
   rank_t best_rank;

   always_comb begin
      best_rank = '1;
      ab.best_valid = 1'b0;
      ab.best_vec = '0;
      for (int i = 0; i < `NUM_VEC; i++) begin
         if (ab.pend[i] && (!ab.best_valid || ab.rank[i] < best_rank)) begin
            ab.best_valid = 1'b1;
            best_rank = ab.rank[i];
            ab.best_vec = vec_t'(i);
         end
      end
      ab.best_grp = ab.best_valid ? best_rank[6:3] : `GRP_BASE;
   end
endmodule : exc_arbiter

// >>> core_model.sv
// Core stand-in: first instruction after reset, return after a fixed handler time.
// Assumes the prioritizer's core handshake, all on pclk.
`timescale 1ns/1ps
module core_model #(
   parameter int HOLD = 12
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Handshake
   input wire logic handler_mode,
   input wire logic tail_chain,
   output logic first_instr,
   output logic exc_return
);
   int bc;
   int hc;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bc <= 0;
         first_instr <= 1'b0;
      end else begin
         bc <= (bc == 4) ? 4 : bc + 1;
         first_instr <= (bc == 3);
      end
   end
   // return once handler has run; never in the tail cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hc <= 0;
         exc_return <= 1'b0;
      end else begin
         hc <= (handler_mode && !tail_chain && !exc_return) ? hc + 1 : 0;
         exc_return <= (hc == HOLD);
      end
   end
endmodule : core_model

// >>> vectored_exception_prioritizer_bench.sv
// Self-checking bench of the exception prioritizer.
// Assumes vep_pkg and core_model are compiled first.
`timescale 1ns/1ps
module vectored_exception_prioritizer_bench;
   import vep_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er;
   logic [47:0] irq = 48'h0;
   logic [6:0] ev = 7'h00;
   logic ce = 1'b1;
   logic first_instr, exc_return, sp_load, vtab_rd, handler_mode, tail_chain, stack_push, stack_pop;
   vec_t active_vec, vtab_index;
   int error_cnt = 0;
   int samples_checked = 0;
   int pushes = 0;
   always #2 pclk = ~pclk;
   always @(posedge pclk) if (stack_push === 1'b1) pushes++;
   vectored_exception_prioritizer i_dut (.pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .irq_lines(irq), .fault_mem_req(ev[0]), .fault_bus_req(ev[4]),
      .fault_bus_precise(!ev[6]), .fault_usage_req(ev[1]), .svc_req(ev[2]), .dbgmon_req(ev[5]),
      .system_tick_exception_req(ev[3]), .first_instr, .exc_return, .sp_load, .vtab_rd, .vtab_index, .stack_push,
      .stack_pop, .tail_chain, .handler_mode, .active_vec);
   core_model i_core (.pclk, .presetn, .handler_mode, .tail_chain, .first_instr, .exc_return);
   task automatic wrap_up;
      $display("Checks %0d, errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50) error_cnt++;
      if (n == 50) wrap_up();
   endtask : apb
   // Waits for an exception state, stack restore finished
   task automatic until_ok(input logic [5:0] v, input logic hm);
      int n;
      for (n = 0; n < 300; n++) begin
         @(posedge pclk);
         if (active_vec === v && handler_mode === hm && stack_pop === 1'b0) break;
      end
      chk({handler_mode, active_vec}, {hm, v});
      if (n == 300) begin
         error_cnt++;
         wrap_up();
      end
   endtask : until_ok
   // Tail cycle must fetch the new vector as well
   task automatic wait_tail(input logic [5:0] v);
      int n;
      for (n = 0; n < 100 && tail_chain !== 1'b1; n++) @(posedge pclk);
      chk({tail_chain, vtab_rd, vtab_index}, {2'b11, v});
      if (n == 100) wrap_up();
   endtask : wait_tail
   task automatic t_regs;
      apb(1'b0, 12'h040, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      apb(1'b1, 12'h008, 32'h3);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h3);
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b1, 12'h044, 32'h7777_7777);
      // Clock enable low across the setup cycle: access must wait, not hang
      @(posedge pclk);
      ce <= 1'b0;
      fork
         apb(1'b0, 12'h044, 32'h0);
         begin
            repeat (3) @(posedge pclk);
            ce <= 1'b1;
         end
      join
      chk(rd, 32'h7700_0007);
      apb(1'b1, 12'h010, 32'hffff_ffff);
      apb(1'b1, 12'h014, 32'hffff_ffff);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, 32'hf3ff_c1ff);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, 32'h0000_0c00);
      apb(1'b1, 12'h018, 32'hffff_ffff);
      apb(1'b1, 12'h01c, 32'hffff_ffff);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, 32'h0);
   endtask : t_regs
   // Pass 0 with fault and monitor handlers off, pass 1 on; 0 means dropped, event 6 imprecise bus
   task automatic t_events;
      logic [5:0] exp [2][7] = '{'{3, 3, 11, 15, 3, 0, 3}, '{4, 6, 11, 15, 5, 12, 5}};
      for (int p = 0; p < 2; p++) begin
         if (p == 1) apb(1'b1, 12'h004, 32'h000f_0000);
         for (int k = 0; k < 7; k++) begin
            @(posedge pclk);
            ev <= (k == 6) ? 7'h50 : 7'h01 << k;
            @(posedge pclk);
            ev <= 7'h00;
            if (exp[p][k] == 6'h00) begin
               repeat (12) @(posedge pclk);
               chk({handler_mode, stack_push, active_vec}, 32'h0);
            end else begin
               until_ok(exp[p][k], 1'b1);
               until_ok(6'h00, 1'b0);
            end
         end
      end
   endtask : t_events
   // Lines pend under the NMI, so both chain in after it
   task automatic t_irq_chain;
      apb(1'b1, 12'h010, 32'h3);
      apb(1'b1, 12'h040, 32'h11);
      pushes = 0;
      apb(1'b1, 12'h000, 32'h8000_0000);
      until_ok(6'h02, 1'b1);
      @(posedge pclk);
      irq <= 48'h3;
      repeat (2) @(posedge pclk);
      irq <= 48'h0;
      wait_tail(6'h10);
      until_ok(6'h10, 1'b1);
      wait_tail(6'h11);
      until_ok(6'h11, 1'b1);
      until_ok(6'h00, 1'b0);
      chk(pushes, 8);
      apb(1'b0, 12'h020, 32'h0);
      chk(rd, 32'h0);
   endtask : t_irq_chain
   task automatic t_nmi;
      apb(1'b1, 12'h000, 32'h9000_0000);
      until_ok(6'h02, 1'b1);
      wait_tail(6'h0e);
      until_ok(6'h0e, 1'b1);
      until_ok(6'h00, 1'b0);
   endtask : t_nmi
   initial begin
      repeat (6) @(posedge pclk);
      chk({sp_load, vtab_rd, vtab_index}, {2'b11, 6'h00});
      presetn <= 1'b1;
      @(posedge pclk);
      #1 chk({vtab_rd, vtab_index, active_vec}, {1'b1, 6'h01, 6'h01});
      until_ok(6'h00, 1'b0);
      t_regs();
      t_events();
      t_irq_chain();
      t_nmi();
      wrap_up();
   end
endmodule : vectored_exception_prioritizer_bench
